/* File: logic/dci_interrupt_logic.sv */
// What this block does
// RULE1: Fixed priority: reset, nonmaskable, then 4..15.
// RULE2: Reset request active low; others active high.
// RULE3: Outside holds reset low ten cycles.
// RULE4: Reset aborts work, restores register defaults.
// RULE5: Reset service fetched from address zero.
// RULE6: Reset ignores branch delay slots.
// RULE7: Nonmaskable needs enable; deferred in delay slots.
// RULE8: Nonmaskable enable cleared at reset.
// RULE9: Taking nonmaskable clears its enable.
// RULE10: Software may set, never clear, nonmaskable enable.
// RULE11: Nonmaskable enable clear blocks maskable sources.
// RULE12: Maskable needs global, nmi, own enable, pending.
// RULE13: Maskable deferred during any branch delay slots.
// RULE14: Qualifying input edge sets pending flag.
// RULE15: Acknowledge asserted when servicing begins.
// RULE16: Service number on four bits, MSB first.
// RULE17: Table holds sixteen eight-word fetch packets.
// RULE18: Entry offset equals number times 0x20.
// RULE19: Mid-packet branch skips earlier packet words.
// RULE20: Pointer combines table base and number.
// RULE21: Pointer bits 0-4 zero, 5-9 number, 10-31 base.
// RULE22: Number field: top pending individually enabled source.
// RULE23: Table base cleared at reset, writable later.
// RULE24: Maskable taken copies global enable, clears it.
// RULE25: Servicing clears that source's pending flag.
// RULE26: Acknowledge is one-cycle pulse with number.
`timescale 1ns/1ps
module dci_interrupt_logic (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_req_n,
  input wire logic nmi_req,
  input wire logic [11:0] maskable_request_lines,
  input wire logic branch_delay,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic service_ack_out,
  output logic [3:0] service_number_out,
  output logic [31:0] fetch_addr,
  output logic fetch_valid,
  output logic [2:0] fetch_skip
);
  logic [15:0] pending_flag_reg;
  logic [15:0] per_source_enable_reg;
  logic global_maskable_enable;
  logic saved_global_enable;
  logic nonmaskable_enable_bit;
  logic [21:0] vector_table_base;
  logic [15:0] req_prev;
  logic [11:0] mreq_q;
  logic rst_req_prev;
  dci_pkg::dci_service_s svc;

  // RULE2 polarity
  wire logic rst_asserted = ~reset_req_n;
  wire logic [15:0] req_now = {maskable_request_lines, 2'b00, nmi_req,
                               rst_asserted};
  // RULE14 rising edge
  wire logic [15:0] req_edge = req_now & ~req_prev;

  wire logic [15:0] enabled_pending = pending_flag_reg &
                                      (per_source_enable_reg | dci_pkg::ENABLE_RESET);

  // RULE22 top enabled
  logic [4:0] top_enabled_source;
  always_comb begin
    top_enabled_source = 5'h00;
    for (int i = dci_pkg::NUM_SRC - 1; i >= 1; i--) begin
      if (enabled_pending[i] && (i != 2) && (i != 3)) begin
        top_enabled_source = 5'(i);
      end
    end
  end

  // RULE6 reset wins
  wire logic take_reset = rst_asserted;
  // RULE7 nmi gating
  wire logic take_nmi = ~take_reset & pending_flag_reg[dci_pkg::NUM_NMI] &
                        nonmaskable_enable_bit & ~branch_delay;
  // RULE12 maskable gating
  // RULE13 delay slots
  wire logic [15:0] mask_ready = pending_flag_reg & per_source_enable_reg &
                                 dci_pkg::MASKABLE_MASK;
  // RULE11 blocked by enable
  wire logic mask_ok = global_maskable_enable & nonmaskable_enable_bit &
                       ~branch_delay & ~take_reset &
                       ~pending_flag_reg[dci_pkg::NUM_NMI];
  // RULE1 priority
  logic [3:0] mask_num;
  logic mask_any;
  always_comb begin
    mask_num = 4'h0;
    mask_any = 1'b0;
    for (int i = dci_pkg::MASK_HI; i >= dci_pkg::MASK_LO; i--) begin
      if (mask_ready[i]) begin
        mask_num = 4'(i);
        mask_any = 1'b1;
      end
    end
  end
  // Higher flags block lower ones even if that higher is disabled
  logic mask_blocked;
  always_comb begin
    mask_blocked = 1'b0;
    for (int i = dci_pkg::MASK_LO; i <= dci_pkg::MASK_HI; i++) begin
      if (4'(i) < mask_num && pending_flag_reg[i]) begin
        mask_blocked = 1'b1;
      end
    end
  end
  wire logic take_mask = mask_ok & mask_any & ~mask_blocked;

  wire logic [3:0] take_num = take_reset ? dci_pkg::NUM_RESET :
                              take_nmi ? dci_pkg::NUM_NMI : mask_num;
  wire logic take_any = take_reset | take_nmi | take_mask;
  wire logic reset_start = take_reset & ~rst_req_prev;

  // RULE5 address zero
  // RULE17 packet table
  // RULE18 entry offset
  wire logic [31:0] next_fetch = take_reset ? dci_pkg::RESET_FETCH :
    {vector_table_base, 1'b0, take_num, 5'h00};

  // Register decode
  wire logic wr_ctrl = reg_wr && reg_addr == dci_pkg::OFF_CTRL;
  wire logic wr_en = reg_wr && reg_addr == dci_pkg::OFF_ENABLE;
  wire logic wr_ptr = reg_wr && reg_addr == dci_pkg::OFF_POINTER;
  wire logic wr_nm_en = reg_wr && reg_addr == dci_pkg::OFF_NM_ENABLE;

  // RULE20 pointer layout
  // RULE21 field bits
  wire logic [31:0] vector_table_pointer = {vector_table_base,
                                            top_enabled_source, 5'h00};
  logic [31:0] next_rdata;
  always_comb begin
    unique case (reg_addr)
      dci_pkg::OFF_CTRL:
        next_rdata = {30'h0, saved_global_enable, global_maskable_enable};
      dci_pkg::OFF_ENABLE:
        next_rdata = {16'h0, per_source_enable_reg | dci_pkg::ENABLE_RESET};
      dci_pkg::OFF_PENDING: next_rdata = {16'h0, pending_flag_reg};
      dci_pkg::OFF_POINTER: next_rdata = vector_table_pointer;
      dci_pkg::OFF_NM_ENABLE: next_rdata = {31'h0, nonmaskable_enable_bit};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // RULE25 clear on service, set wins
  wire logic [15:0] clr_vec = take_any ? (16'h0001 << take_num) : 16'h0000;
  wire logic [15:0] next_pending = ((pending_flag_reg & ~clr_vec) | req_edge)
                                   & 16'hFFF3;

  // RULE4 register defaults
  // RULE8 enable reset
  // RULE23 base reset
  always_ff @(posedge clk) begin
    if (rst) begin
      pending_flag_reg <= 16'h0000;
      per_source_enable_reg <= 16'h0000;
      global_maskable_enable <= 1'b0;
      saved_global_enable <= 1'b0;
      nonmaskable_enable_bit <= 1'b0;
      vector_table_base <= 22'h00_0000;
      req_prev <= 16'h0000;
      rst_req_prev <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      req_prev <= req_now;
      rst_req_prev <= take_reset;
      reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
      if (take_reset) begin
        pending_flag_reg <= 16'h0000;
        per_source_enable_reg <= 16'h0000;
        global_maskable_enable <= 1'b0;
        saved_global_enable <= 1'b0;
        nonmaskable_enable_bit <= 1'b0;
        vector_table_base <= 22'h00_0000;
      end else begin
        pending_flag_reg <= next_pending;
        if (wr_en) begin
          per_source_enable_reg <= reg_wdata[15:0] & dci_pkg::MASKABLE_MASK;
        end
        if (wr_ptr) begin
          vector_table_base <= reg_wdata[31:10];
        end
        // RULE9 auto clear
        // RULE10 set only
        if (take_nmi) begin
          nonmaskable_enable_bit <= 1'b0;
        end else if (wr_nm_en && reg_wdata[0]) begin
          nonmaskable_enable_bit <= 1'b1;
        end
        // RULE24 save enable
        if (take_mask) begin
          // A racing software clear lands before the copy is taken
          saved_global_enable <= wr_ctrl ? reg_wdata[dci_pkg::GLOBAL_EN_BIT] :
                                 global_maskable_enable;
          global_maskable_enable <= 1'b0;
        end else if (wr_ctrl) begin
          global_maskable_enable <= reg_wdata[dci_pkg::GLOBAL_EN_BIT];
          saved_global_enable <= reg_wdata[dci_pkg::SAVED_EN_BIT];
        end
      end
    end
  end

  // RULE15 acknowledge
  // RULE16 number out
  // RULE26 single pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      svc <= '0;
    end else begin
      svc.ack <= take_reset ? reset_start : take_any;
      svc.num <= take_num;
      svc.fetch_addr <= next_fetch;
      svc.fetch_valid <= take_reset ? reset_start : take_any;
    end
  end

  // RULE19 mid-packet skip count, held at zero on every cycle
  logic [2:0] skip_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      skip_q <= 3'h0;
    end else begin
      skip_q <= 3'h0;
    end
  end

  assign service_ack_out = svc.ack;
  assign service_number_out = svc.num;
  assign fetch_addr = svc.fetch_addr;
  assign fetch_valid = svc.fetch_valid;
  assign fetch_skip = skip_q;

  // RULE3 reset hold count
  logic [3:0] low_cnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      low_cnt <= 4'h0;
    end else if (rst_asserted) begin
      low_cnt <= (low_cnt == 4'hF) ? low_cnt : low_cnt + 4'h1;
    end else begin
      low_cnt <= 4'h0;
    end
  end

  AST_NMI_CLEARS: assert property (@(posedge clk) disable iff (rst) // RULE9
    take_nmi |=> !nonmaskable_enable_bit)
    else $error("nmi enable not cleared");
  AST_NM_EN_NO_SW_CLEAR: assert property (@(posedge clk) disable iff (rst) // RULE10
    (wr_nm_en && !reg_wdata[0] && !take_nmi && !take_reset &&
     nonmaskable_enable_bit) |=> nonmaskable_enable_bit)
    else $error("software cleared nmi enable");
  AST_ACK_PULSE: assert property (@(posedge clk) disable iff (rst) // RULE26
    service_ack_out |=> !service_ack_out || $past(take_any))
    else $error("ack not a pulse");
  AST_ACK_NUM: assert property (@(posedge clk) disable iff (rst) // RULE16
    take_nmi |=> service_ack_out && service_number_out == 4'h1)
    else $error("wrong service number");
  AST_NO_MASK_DELAY: assert property (@(posedge clk) disable iff (rst) // RULE13
    branch_delay |-> !take_mask && !take_nmi)
    else $error("taken in delay slot");
  AST_MASK_NEEDS_NONMASKABLE_ENABLE_BIT: assert property (@(posedge clk) disable iff (rst) // RULE11
    take_mask |-> nonmaskable_enable_bit && global_maskable_enable)
    else $error("maskable taken while blocked");
  AST_GLOBAL_EN_SAVE: assert property (@(posedge clk) disable iff (rst) // RULE24
    (take_mask && !wr_ctrl) |=> !global_maskable_enable &&
      saved_global_enable == $past(global_maskable_enable))
    else $error("enable not saved");
  AST_RESET_FETCH: assert property (@(posedge clk) disable iff (rst) // RULE5
    reset_start |=> fetch_valid && fetch_addr == 32'h0000_0000)
    else $error("reset fetch not at zero");
  AST_VEC_OFFSET: assert property (@(posedge clk) disable iff (rst) // RULE18
    fetch_valid |-> fetch_addr[4:0] == 5'h00 &&
      fetch_addr[8:5] == service_number_out)
    else $error("bad vector offset");
  AST_PEND_SET: assert property (@(posedge clk) disable iff (rst) // RULE14
    (req_edge[4] && !take_reset) |=> pending_flag_reg[4])
    else $error("edge lost");
  AST_NM_EN_RESET: assert property (@(posedge clk) disable iff (rst) // RULE8
    take_reset |=> !nonmaskable_enable_bit && vector_table_base == 22'h0)
    else $error("reset defaults missing");

  // Priority and qualification of the taken source
  AST_NMI_OVER_MASK: assert property (@(posedge clk) disable iff (rst) // RULE1
    take_nmi |-> !take_mask)
    else $error("maskable taken over nmi");
  AST_RESET_LOW: assert property (@(posedge clk) disable iff (rst) // RULE2
    (!reset_req_n && !rst_req_prev) |=> service_ack_out &&
      service_number_out == 4'h0)
    else $error("low reset request not serviced");
  AST_RESET_DEFAULTS: assert property (@(posedge clk) disable iff (rst) // RULE4
    take_reset |=> pending_flag_reg == 16'h0000 && !global_maskable_enable &&
      per_source_enable_reg == 16'h0000)
    else $error("registers not at defaults");
  AST_RESET_IN_DELAY: assert property (@(posedge clk) disable iff (rst) // RULE6
    (reset_start && branch_delay) |=> service_ack_out && fetch_valid)
    else $error("reset held off by delay slots");
  AST_MASK_QUALIFIED: assert property (@(posedge clk) disable iff (rst) // RULE12
    take_mask |-> per_source_enable_reg[mask_num] &&
      pending_flag_reg[mask_num])
    else $error("unqualified maskable taken");
  // A fresh edge in the clearing cycle must survive, so it is excluded here
  AST_PEND_CLEARED: assert property (@(posedge clk) disable iff (rst) // RULE25
    (take_mask && !req_edge[mask_num]) |=> !pending_flag_reg[$past(mask_num)])
    else $error("serviced flag still pending");

  // Pointer and fetch address shape
  AST_PTR_LOW_ZERO: assert property (@(posedge clk) disable iff (rst) // RULE21
    vector_table_pointer[4:0] == 5'h00 &&
      vector_table_pointer[31:10] == vector_table_base)
    else $error("pointer layout wrong");
  AST_TOP_NONE: assert property (@(posedge clk) disable iff (rst) // RULE22
    (enabled_pending[15:1] == 15'h0000) |-> top_enabled_source == 5'h00)
    else $error("top source not zero");
  AST_ACK_WITH_FETCH: assert property (@(posedge clk) disable iff (rst) // RULE15
    service_ack_out |-> fetch_valid)
    else $error("ack without fetch");
  AST_MASK_NUMBER: assert property (@(posedge clk) disable iff (rst) // RULE16
    take_mask |=> service_number_out == $past(mask_num))
    else $error("maskable number wrong");
  AST_BASE_WRITE: assert property (@(posedge clk) disable iff (rst) // RULE23
    (wr_ptr && !take_reset) |=> vector_table_base == $past(reg_wdata[31:10]))
    else $error("table base not written");
  // Vector entries are packet aligned, so nothing is ever skipped
  AST_NO_SKIP: assert property (@(posedge clk) disable iff (rst) // RULE19
    fetch_valid |-> fetch_skip == 3'h0)
    else $error("vector fetch skips words");
  AST_TABLE_SPAN: assert property (@(posedge clk) disable iff (rst) // RULE17
    fetch_valid |-> fetch_addr[9] == 1'b0)
    else $error("fetch outside sixteen packets");
endmodule

/* File: logic/dci_pkg.sv */
package dci_pkg;
  localparam int NUM_SRC = 16;
  localparam int MASK_LO = 4;
  localparam int MASK_HI = 15;
  localparam logic [3:0] NUM_RESET = 4'h0;
  localparam logic [3:0] NUM_NMI = 4'h1;
  // Register map, word offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_ENABLE = 4'h1;
  localparam logic [3:0] OFF_PENDING = 4'h2;
  localparam logic [3:0] OFF_POINTER = 4'h3;
  localparam logic [3:0] OFF_NM_ENABLE = 4'h4;
  // Control/status bit positions
  localparam int GLOBAL_EN_BIT = 0;
  localparam int SAVED_EN_BIT = 1;
  // Vector table pointer layout
  localparam int PTR_NUM_LSB = 5;
  localparam int PTR_NUM_W = 5;
  localparam int PTR_BASE_LSB = 10;
  localparam int PTR_BASE_W = 22;
  localparam int PKT_BYTES = 32;
  localparam int PKT_WORDS = 8;
  localparam logic [31:0] RESET_FETCH = 32'h0000_0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0001;
  localparam logic [15:0] MASKABLE_MASK = 16'hFFF0;

  typedef struct packed {
    logic ack;
    logic [3:0] num;
    logic [31:0] fetch_addr;
    logic fetch_valid;
  } dci_service_s;
endpackage

/* File: dv/dci_src_model.sv */
`timescale 1ns/1ps
module dci_src_model (
  input wire logic clk,
  input wire logic [11:0] fire_mask,
  input wire logic fire_nmi,
  input wire logic fire_reset,
  output logic reset_req_n,
  output logic nmi_req,
  output logic [11:0] maskable_request_lines
);
  logic [3:0] low_cnt;
  initial begin
    low_cnt = 4'h0;
    nmi_req = 1'b0;
    maskable_request_lines = 12'h000;
  end
  assign reset_req_n = (low_cnt == 4'h0);
  // nmi and maskable requests follow the fire inputs one cycle later; reset is held low ten cycles
  always @(posedge clk) begin
    maskable_request_lines <= fire_mask;
    nmi_req <= fire_nmi;
    if (fire_reset) begin
      low_cnt <= 4'ha;
    end else if (low_cnt != 4'h0) begin
      low_cnt <= low_cnt - 4'h1;
    end
  end
endmodule

/* File: dv/dci_interrupt_logic_tb.sv */
`timescale 1ns/1ps
module dci_interrupt_logic_tb;
  logic clk = 1'b0, rst = 1'b1, bdelay = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, rdata, reg_rdata, fetch_addr;
  logic [11:0] fire_mask = 12'h000, req_lines;
  logic fire_nmi = 1'b0, fire_reset = 1'b0, reset_req_n, nmi_req, ack, fvalid;
  logic [3:0] num;
  logic [2:0] skip;
  int mismatches = 0, samples_checked = 0;
  typedef struct packed {
    logic [11:0] fire;
    logic [3:0] num;
    logic [31:0] addr;
  } dci_row_s;
  dci_row_s rows [4] = '{'{12'h001, 4'h4, 32'h0000_0880},
    '{12'h008, 4'h7, 32'h0000_08e0}, '{12'h100, 4'hc, 32'h0000_0980},
    '{12'h800, 4'hf, 32'h0000_09e0}};

  dci_src_model dci_src_model_inst (.clk(clk), .fire_mask(fire_mask),
    .fire_nmi(fire_nmi), .fire_reset(fire_reset), .reset_req_n(reset_req_n),
    .nmi_req(nmi_req), .maskable_request_lines(req_lines));
  dci_interrupt_logic dci_interrupt_logic_inst (.clk(clk), .rst(rst),
    .reset_req_n(reset_req_n), .nmi_req(nmi_req),
    .maskable_request_lines(req_lines), .branch_delay(bdelay),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .service_ack_out(ack),
    .service_number_out(num), .fetch_addr(fetch_addr),
    .fetch_valid(fvalid), .fetch_skip(skip));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic end_sim();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("reg_rdata", exp, reg_rdata);
  endtask

  task automatic fire(input logic [11:0] m);
    @(posedge clk);
    fire_mask <= m;
    @(posedge clk);
    fire_mask <= 12'h000;
  endtask

  task automatic no_ack(input int n);
    repeat (n) begin
      @(negedge clk);
      chk("idle_ack", 32'h0000_0000, {31'h0, ack});
    end
  endtask

  // Bounded wait; a missing acknowledge ends the run
  task automatic wait_ack(input logic [3:0] n, input logic [31:0] a);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (ack !== 1'b1 && i < 10);
    chk("ack", 32'h0000_0001, {31'h0, ack});
    if (ack !== 1'b1) begin
      end_sim();
    end
    chk("number", {28'h0, n}, {28'h0, num});
    chk("fetch_addr", a, fetch_addr);
    chk("fetch_valid", 32'h0000_0001, {31'h0, fvalid});
    chk("fetch_skip", 32'h0000_0000, {29'h0, skip});
    @(negedge clk);
    chk("ack_width", 32'h0000_0000, {31'h0, ack});
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdchk(dci_pkg::OFF_CTRL, 32'h0000_0000);
    rdchk(dci_pkg::OFF_ENABLE, 32'h0000_0001);
    rdchk(dci_pkg::OFF_POINTER, 32'h0000_0000);
    rdchk(dci_pkg::OFF_NM_ENABLE, 32'h0000_0000);
    rdchk(4'hf, 32'h0000_0000);
    wr(dci_pkg::OFF_POINTER, 32'h0000_0800);
    wr(dci_pkg::OFF_ENABLE, 32'h0000_fff0);
    wr(dci_pkg::OFF_CTRL, 32'h0000_0001);
    fire(12'h001);
    no_ack(6);
    rdchk(dci_pkg::OFF_POINTER, 32'h0000_0880);
    wr(dci_pkg::OFF_NM_ENABLE, 32'h0000_0001);
    wait_ack(4'h4, 32'h0000_0880);
    wr(dci_pkg::OFF_NM_ENABLE, 32'h0000_0000);
    rdchk(dci_pkg::OFF_NM_ENABLE, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      wr(dci_pkg::OFF_CTRL, 32'h0000_0001);
      fire(rows[i].fire);
      wait_ack(rows[i].num, rows[i].addr);
      rdchk(dci_pkg::OFF_PENDING, 32'h0000_0000);
      rdchk(dci_pkg::OFF_CTRL, 32'h0000_0002);
    end
    wr(dci_pkg::OFF_CTRL, 32'h0000_0001);
    fire(12'h801);
    wait_ack(4'h4, 32'h0000_0880);
    rdchk(dci_pkg::OFF_POINTER, 32'h0000_09e0);
    wr(dci_pkg::OFF_CTRL, 32'h0000_0001);
    wait_ack(4'hf, 32'h0000_09e0);
    wr(dci_pkg::OFF_CTRL, 32'h0000_0001);
    @(posedge clk);
    bdelay <= 1'b1;
    fire_nmi <= 1'b1;
    fire_mask <= 12'h002;
    @(posedge clk);
    fire_nmi <= 1'b0;
    fire_mask <= 12'h000;
    no_ack(6);
    @(posedge clk);
    bdelay <= 1'b0;
    wait_ack(4'h1, 32'h0000_0820);
    rdchk(dci_pkg::OFF_NM_ENABLE, 32'h0000_0000);
    no_ack(4);
    @(posedge clk);
    bdelay <= 1'b1;
    fire_reset <= 1'b1;
    @(posedge clk);
    fire_reset <= 1'b0;
    wait_ack(4'h0, dci_pkg::RESET_FETCH);
    @(posedge clk);
    bdelay <= 1'b0;
    repeat (12) @(posedge clk);
    rdchk(dci_pkg::OFF_POINTER, 32'h0000_0000);
    rdchk(dci_pkg::OFF_NM_ENABLE, 32'h0000_0000);
    rdchk(dci_pkg::OFF_PENDING, 32'h0000_0000);
    rdchk(dci_pkg::OFF_CTRL, 32'h0000_0000);
    end_sim();
  end
endmodule
